//--- logic/ccu_pkg.sv
package ccu_pkg;
  // Channel count and bus widths
  localparam int NUM_CH = 7;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int PRESC_W = 4;

  // Byte offsets inside one channel slot (slot base = channel index * 4)
  localparam logic [1:0] OFF_CTRL = 2'h0;
  localparam logic [1:0] OFF_VAL_LOW = 2'h1;
  localparam logic [1:0] OFF_VAL_HIGH = 2'h2;
  // Shared registers live in the eighth slot
  localparam logic [2:0] SLOT_SHARED = 3'h7;
  localparam logic [1:0] OFF_TSEL_LOW = 2'h0;
  localparam logic [1:0] OFF_TSEL_HIGH = 2'h1;
  localparam logic [1:0] OFF_FLAGS = 2'h2;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DUTY_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VAL_RESET = 8'h00;
  localparam logic [7:0] TSEL_RESET = 8'h00;

  // Implemented bits of the timer-select registers
  localparam logic [7:0] TSEL_LOW_MASK = 8'hD7;
  localparam logic [7:0] TSEL_HIGH_MASK_FULL = 8'h17;
  localparam logic [7:0] TSEL_HIGH_MASK_SMALL = 8'h03;

  // Mode field codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW = 4'h9;
  localparam logic [3:0] MODE_SOFT_IRQ = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  localparam logic [1:0] CLASS_CAPTURE = 2'h1;
  localparam logic [1:0] CLASS_COMPARE = 2'h2;
  localparam logic [1:0] CLASS_PWM = 2'h3;

  // Prescaler terminal counts
  localparam logic [1:0] PRESC4_LAST = 2'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hF;

  // Timer indices: 16-bit list is timers 1,3,5,7; 8-bit list is 2,4,6
  localparam logic [1:0] T16_1 = 2'h0;
  localparam logic [1:0] T16_3 = 2'h1;
  localparam logic [1:0] T16_5 = 2'h2;
  localparam logic [1:0] T16_7 = 2'h3;
  localparam logic [1:0] T8_2 = 2'h0;
  localparam logic [1:0] T8_4 = 2'h1;
  localparam logic [1:0] T8_6 = 2'h2;
endpackage

//--- logic/ccu_channel.sv
`timescale 1ns/1ns
`default_nettype none
// One capture/compare/PWM channel with its data register
module ccu_channel (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] mode_in,
  input wire logic [1:0] duty_low_in,
  input wire logic low_wr_in,
  input wire logic high_wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [15:0] cc_timer_in,
  input wire logic [9:0] pwm_count_in,
  input wire logic pwm_period_in,
  input wire logic cap_pin_in,
  input wire logic port_latch_in,
  output logic [7:0] value_low_out,
  output logic [7:0] value_high_out,
  output logic irq_set_out,
  output logic trigger_out,
  output logic pin_out,
  output logic pin_oe_out
);
  import ccu_pkg::*;

  logic sync1_r, sync2_r, sync3_r;
  logic [PRESC_W-1:0] presc_r;
  logic cap_now_r, eq_r, latch_r, pwm_r;
  logic [3:0] mode_prev_r;
  logic [9:0] duty_buf_r;
  logic is_cap, is_cmp, is_pwm, rise, fall, qual, eq, match;
  logic latch_nxt, pwm_nxt;

  // Mode classes
  assign is_cap = (mode_in[3:2] == CLASS_CAPTURE);
  assign is_pwm = (mode_in[3:2] == CLASS_PWM);
  assign is_cmp = (mode_in[3:2] == CLASS_COMPARE) || (mode_in == MODE_TOGGLE);

  // Two-stage synchroniser; the second and third stages feed edge detection
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= cap_pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign rise = sync2_r & ~sync3_r;
  assign fall = ~sync2_r & sync3_r;

  // Prescaler cleared outside capture, kept across prescaler changes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_r <= '0;
    end else if (!is_cap) begin
      presc_r <= '0;
    end else if (rise) begin
      presc_r <= presc_r + 4'h1;
    end
  end

  // Qualifying capture event
  always_comb begin
    qual = 1'b0;
    case (mode_in)
      MODE_CAP_FALL: qual = fall;
      MODE_CAP_RISE: qual = rise;
      MODE_CAP_RISE4: qual = rise && (presc_r[1:0] == PRESC4_LAST);
      MODE_CAP_RISE16: qual = rise && (presc_r == PRESC16_LAST);
      default: qual = 1'b0;
    endcase
  end

  // Capture latches the timer one cycle after the edge is seen
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_now_r <= 1'b0;
    end else begin
      cap_now_r <= qual & is_cap;
    end
  end

  // Match on the first cycle of equality, so a stalled timer fires once
  assign eq = ({value_high_out, value_low_out} == cc_timer_in);
  assign match = is_cmp & eq & ~eq_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      eq_r <= 1'b0;
      mode_prev_r <= MODE_OFF;
    end else begin
      eq_r <= eq & is_cmp;
      mode_prev_r <= mode_in;
    end
  end

  // Data register: capture wins over a software write in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_low_out <= VAL_RESET;
      value_high_out <= VAL_RESET;
    end else begin
      if (cap_now_r) begin
        value_low_out <= cc_timer_in[7:0];
      end else if (low_wr_in) begin
        value_low_out <= wdata_in;
      end
      if (cap_now_r) begin
        value_high_out <= cc_timer_in[15:8];
      end else if (is_pwm && pwm_period_in) begin
        value_high_out <= value_low_out;
      end else if (high_wr_in) begin
        value_high_out <= wdata_in;
      end
    end
  end

  // Compare latch and PWM level, next values
  always_comb begin
    latch_nxt = latch_r;
    if (mode_in == MODE_OFF) begin
      latch_nxt = 1'b0;
    end else if (mode_in != mode_prev_r) begin
      if (mode_in == MODE_SET_HIGH) begin
        latch_nxt = 1'b0;
      end else if (mode_in == MODE_SET_LOW) begin
        latch_nxt = 1'b1;
      end
    end else if (match) begin
      case (mode_in)
        MODE_TOGGLE: latch_nxt = ~latch_r;
        MODE_SET_HIGH: latch_nxt = 1'b1;
        MODE_SET_LOW: latch_nxt = 1'b0;
        default: latch_nxt = latch_r;
      endcase
    end
    pwm_nxt = pwm_r;
    if (!is_pwm) begin
      pwm_nxt = 1'b0;
    end else if (pwm_period_in) begin
      pwm_nxt = ({value_low_out, duty_low_in} != 10'h000);
    end else if (pwm_count_in == duty_buf_r) begin
      pwm_nxt = 1'b0;
    end
  end

  // Duty buffer reloads only at the period boundary, giving glitch-free updates
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      duty_buf_r <= 10'h000;
    end else if (!is_pwm) begin
      duty_buf_r <= 10'h000;
    end else if (pwm_period_in) begin
      duty_buf_r <= {value_low_out, duty_low_in};
    end
  end

  // Pin, latches and event pulses change on the same edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_r <= 1'b0;
      pwm_r <= 1'b0;
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
      irq_set_out <= 1'b0;
      trigger_out <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      pwm_r <= pwm_nxt;
      pin_out <= is_pwm ? pwm_nxt : (mode_in == MODE_SOFT_IRQ) ? port_latch_in : latch_nxt;
      pin_oe_out <= is_pwm | is_cmp;
      irq_set_out <= match | cap_now_r;
      trigger_out <= match && (mode_in == MODE_SPECIAL);
    end
  end
endmodule
`default_nettype wire

//--- logic/ccu_top.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Mode zero disables the channel and clears its state; codes 1 and 3 reserved.
// - Toggle compare inverts the pin and sets the flag on each match.
// - Modes 4 and 5 capture the timer on falling or rising input edges.
// - Modes 6 and 7 capture on every fourth or sixteenth rising edge.
// - Mode 8 starts the pin low, drives it high on match, sets flag.
// - Mode 9 starts the pin high, drives it low on match, sets flag.
// - Mode 10 only sets the flag; pin shows the port latch.
// - Mode 11 sets the flag and resets the channel's assigned 16-bit timer.
// - The trigger resets the timer only and never starts a conversion.
// - Modes 11xx are PWM; duty is low byte plus control bits 5-4.
// - Control bits 7-6 read zero; duty bits unused outside PWM.
// - Data register is capture, compare or duty; high byte buffers duty.
// - Channel 5 select: 0 gives T1/T2, 1 gives T5/T4.
// - Small variant channel 8: compare T1 always; PWM T2, T4, T6.
// - All channels run at once and may share one timer.
// - PWM uses 8-bit timers 2,4,6; compare uses 16-bit 1,3,5,7.
// - Small variant drops channels 9 and 10; their select bits read zero.
// - Each capture sets the flag; newer capture overwrites the old value.
// - Prescaler clears when off or not capturing, not on prescaler changes.
// - Compare runs continuously; the flag sets one cycle after the pin action.
module ccu_top #(
  parameter bit SMALL_MEM = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ccu_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ccu_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [ccu_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [ccu_pkg::NUM_CH-1:0] cap_pin_in,
  input wire logic [ccu_pkg::NUM_CH-1:0] port_latch_in,
  output logic [ccu_pkg::NUM_CH-1:0] pin_out_out,
  output logic [ccu_pkg::NUM_CH-1:0] pin_oe_out,
  output logic [ccu_pkg::NUM_CH-1:0] irq_flag_out,
  input wire logic [63:0] tmr16_count_in,
  input wire logic [31:0] tmr8_count_in,
  input wire logic [7:0] tmr8_fine_in,
  input wire logic [3:0] tmr8_period_in,
  output logic [3:0] tmr16_reset_out
);
  import ccu_pkg::*;

  logic [5:0] ctrl_r [NUM_CH];
  logic [7:0] tsel_low_r, tsel_high_r;
  logic [7:0] tsel_high_mask;
  logic [1:0] cc_idx [NUM_CH];
  logic [1:0] pwm_idx [NUM_CH];
  logic [7:0] val_low [NUM_CH];
  logic [7:0] val_high [NUM_CH];
  logic [NUM_CH-1:0] irq_set, trig, ch_pin, ch_oe;
  logic [NUM_CH-1:0] present, low_wr, high_wr, flag_clr;
  logic [2:0] slot;
  logic [1:0] off;
  logic [3:0] reset_nxt;

  assign slot = reg_addr_in[4:2];
  assign off = reg_addr_in[1:0];
  assign tsel_high_mask = SMALL_MEM ? TSEL_HIGH_MASK_SMALL : TSEL_HIGH_MASK_FULL;

  // Which channels exist in this variant
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      present[i] = !(SMALL_MEM && (i >= 5));
    end
  end

  // Per-channel write strobes for the data bytes
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      low_wr[i] = reg_wr_in && present[i] && (slot == 3'(i)) && (off == OFF_VAL_LOW);
      high_wr[i] = reg_wr_in && present[i] && (slot == 3'(i)) && (off == OFF_VAL_HIGH);
    end
  end

  // Control registers; bits 7-6 are not stored
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl_r[i] <= CTRL_RESET[5:0];
      end
    end else if (reg_wr_in && (slot != SLOT_SHARED) && (off == OFF_CTRL)) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if ((slot == 3'(i)) && present[i]) begin
          ctrl_r[i] <= reg_wdata_in[5:0];
        end
      end
    end
  end

  // Timer-select registers keep only their implemented bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tsel_low_r <= TSEL_RESET;
      tsel_high_r <= TSEL_RESET;
    end else if (reg_wr_in && (slot == SLOT_SHARED)) begin
      if (off == OFF_TSEL_LOW) begin
        tsel_low_r <= reg_wdata_in & TSEL_LOW_MASK;
      end else if (off == OFF_TSEL_HIGH) begin
        tsel_high_r <= reg_wdata_in & tsel_high_mask;
      end
    end
  end

  // Write-one-to-clear of the flags
  always_comb begin
    flag_clr = '0;
    if (reg_wr_in && (slot == SLOT_SHARED) && (off == OFF_FLAGS)) begin
      flag_clr = reg_wdata_in[NUM_CH-1:0];
    end
  end

  // Flags are sticky; a hardware set in the clear cycle is kept
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_flag_out <= '0;
    end else begin
      irq_flag_out <= (irq_flag_out & ~flag_clr) | irq_set;
    end
  end

  // Timer routing; reserved codes fall back to timers 1 and 2
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      cc_idx[i] = T16_1;
      pwm_idx[i] = T8_2;
    end
    case (tsel_low_r[1:0])
      2'h1: begin
        cc_idx[0] = T16_3;
        pwm_idx[0] = T8_4;
      end
      2'h2: begin
        cc_idx[0] = T16_3;
        pwm_idx[0] = T8_6;
      end
      default: begin
        cc_idx[0] = T16_1;
        pwm_idx[0] = T8_2;
      end
    endcase
    if (tsel_low_r[2]) begin
      cc_idx[1] = T16_5;
      pwm_idx[1] = T8_4;
    end
    if (tsel_low_r[4]) begin
      cc_idx[2] = T16_5;
    end
    case (tsel_low_r[7:6])
      2'h1: begin
        cc_idx[3] = T16_5;
        pwm_idx[3] = T8_4;
      end
      2'h2: begin
        cc_idx[3] = T16_5;
        pwm_idx[3] = T8_6;
      end
      default: begin
        cc_idx[3] = T16_1;
        pwm_idx[3] = T8_2;
      end
    endcase
    case (tsel_high_r[1:0])
      2'h1: begin
        cc_idx[4] = SMALL_MEM ? T16_1 : T16_7;
        pwm_idx[4] = T8_4;
      end
      2'h2: begin
        cc_idx[4] = SMALL_MEM ? T16_1 : T16_7;
        pwm_idx[4] = T8_6;
      end
      default: begin
        cc_idx[4] = T16_1;
        pwm_idx[4] = T8_2;
      end
    endcase
    if (tsel_high_r[2]) begin
      cc_idx[5] = T16_7;
      pwm_idx[5] = T8_4;
    end
    if (tsel_high_r[4]) begin
      cc_idx[6] = T16_7;
    end
  end

  // Channels; compare taps only 16-bit timers, PWM only 8-bit ones
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
    if (!(SMALL_MEM && (g >= 5))) begin : gen_on
      ccu_channel u_ch (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .mode_in(ctrl_r[g][3:0]),
        .duty_low_in(ctrl_r[g][5:4]),
        .low_wr_in(low_wr[g]),
        .high_wr_in(high_wr[g]),
        .wdata_in(reg_wdata_in),
        .cc_timer_in(tmr16_count_in[cc_idx[g]*16 +: 16]),
        .pwm_count_in({tmr8_count_in[pwm_idx[g]*8 +: 8],
          tmr8_fine_in[pwm_idx[g]*2 +: 2]}),
        .pwm_period_in(tmr8_period_in[pwm_idx[g]]),
        .cap_pin_in(cap_pin_in[g]),
        .port_latch_in(port_latch_in[g]),
        .value_low_out(val_low[g]),
        .value_high_out(val_high[g]),
        .irq_set_out(irq_set[g]),
        .trigger_out(trig[g]),
        .pin_out(ch_pin[g]),
        .pin_oe_out(ch_oe[g])
      );
    end else begin : gen_off
      assign val_low[g] = 8'h00;
      assign val_high[g] = 8'h00;
      assign irq_set[g] = 1'b0;
      assign trig[g] = 1'b0;
      assign ch_pin[g] = 1'b0;
      assign ch_oe[g] = 1'b0;
    end
  end

  assign pin_out_out = ch_pin;
  assign pin_oe_out = ch_oe;

  // Timers may be shared by many channels, so triggers are OR-ed per timer
  always_comb begin
    reset_nxt = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (trig[i]) begin
        reset_nxt[cc_idx[i]] = 1'b1;
      end
    end
  end

  // Timer reset pulse; no conversion-start output exists at all
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tmr16_reset_out <= 4'h0;
    end else begin
      tmr16_reset_out <= reset_nxt;
    end
  end

  // Read port: data in the cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 8'h00;
    end else if (slot == SLOT_SHARED) begin
      if (off == OFF_TSEL_LOW) begin
        reg_rdata_out <= tsel_low_r;
      end else if (off == OFF_TSEL_HIGH) begin
        reg_rdata_out <= tsel_high_r;
      end else if (off == OFF_FLAGS) begin
        reg_rdata_out <= {1'b0, irq_flag_out};
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end else if (!present[slot]) begin
      reg_rdata_out <= 8'h00;
    end else if (off == OFF_CTRL) begin
      reg_rdata_out <= {2'b00, ctrl_r[slot]};
    end else if (off == OFF_VAL_LOW) begin
      reg_rdata_out <= val_low[slot];
    end else if (off == OFF_VAL_HIGH) begin
      reg_rdata_out <= val_high[slot];
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- sim/ccu_timer_model.sv
`timescale 1ns/1ns
`default_nettype none
// Timer bank on the far side: four 16-bit counters and four 8-bit counters
module ccu_timer_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [15:0] load_val_in,
  input wire logic [3:0] tmr16_reset_in,
  output logic [63:0] tmr16_count_out,
  output logic [31:0] tmr8_count_out,
  output logic [7:0] tmr8_fine_out,
  output logic [3:0] tmr8_period_out
);
  logic [9:0] ext_r;
  // Timer k loads value plus k*0x1000 so a wrong select never matches
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tmr16_count_out <= 64'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (tmr16_reset_in[k]) begin
          tmr16_count_out[16*k +: 16] <= 16'h0000;
        end else if (load_in) begin
          tmr16_count_out[16*k +: 16] <= load_val_in + 16'(k * 4096);
        end else if (run_in) begin
          tmr16_count_out[16*k +: 16] <= tmr16_count_out[16*k +: 16] + 16'h0001;
        end
      end
    end
  end
  // PWM time bases run free; one shared 10-bit count keeps them in step
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_r <= 10'h000;
    end else begin
      ext_r <= ext_r + 10'h001;
    end
  end
  assign tmr8_count_out = {4{ext_r[9:2]}};
  assign tmr8_fine_out = {4{ext_r[1:0]}};
  assign tmr8_period_out = {4{ext_r == 10'h000}};
endmodule
`default_nettype wire

//--- sim/ccu_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// Port checks; the first channel's mode is shadowed from bus writes
module ccu_top_checker
  import ccu_pkg::*;
#(
  parameter bit SMALL_MEM = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ccu_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ccu_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ccu_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [ccu_pkg::NUM_CH-1:0] port_latch_in,
  input wire logic [ccu_pkg::NUM_CH-1:0] pin_out_out,
  input wire logic [ccu_pkg::NUM_CH-1:0] pin_oe_out,
  input wire logic [ccu_pkg::NUM_CH-1:0] irq_flag_out,
  input wire logic [3:0] tmr16_reset_out
);
  logic [3:0] mode0_r;
  // Shadow mode of channel 0, updated when software writes its control
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode0_r <= 4'h0;
    end else if (reg_wr_in && reg_addr_in == 5'h00) begin
      mode0_r <= reg_wdata_in[3:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ctrl_top_zero_a: assert property (
    $past(reg_rd_in) && $past(reg_addr_in[1:0]) == OFF_CTRL
    && $past(reg_addr_in[4:2]) != SLOT_SHARED |-> reg_rdata_out[7:6] == 2'b00)
    else $error("control read shows bits 7-6 set");
  tsel_low_bits_a: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == 5'h1C |-> (reg_rdata_out & 8'h28) == 8'h00)
    else $error("low select read shows unimplemented bits");
  tsel_high_bits_a: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == 5'h1D
    |-> (reg_rdata_out & (SMALL_MEM ? 8'hFC : 8'hE8)) == 8'h00)
    else $error("high select read shows unimplemented bits");
  flag_sticky_a: assert property (
    |($past(irq_flag_out) & ~irq_flag_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == 5'h1E)
    else $error("flag dropped without a software clear");
  trig_flag_a: assert property (
    |tmr16_reset_out |=> irq_flag_out != 7'h00)
    else $error("timer reset without a flag");
  trig_pulse_a: assert property (
    tmr16_reset_out[0] |=> !tmr16_reset_out[0])
    else $error("timer reset longer than one cycle");
  capture_no_drive_a: assert property (
    mode0_r[3:2] == 2'b01 && $past(mode0_r[3:2]) == 2'b01 |-> !pin_oe_out[0])
    else $error("pin driven in capture mode");
  pwm_drive_a: assert property (
    mode0_r[3:2] == 2'b11 && $past(mode0_r[3:2]) == 2'b11 |-> pin_oe_out[0])
    else $error("pin not driven in pwm mode");
  off_pin_low_a: assert property (
    mode0_r == MODE_OFF && $past(mode0_r) == MODE_OFF |-> !pin_out_out[0] && !pin_oe_out[0])
    else $error("pin not low while channel off");
  soft_irq_pin_a: assert property (
    mode0_r == MODE_SOFT_IRQ && $past(mode0_r, 2) == MODE_SOFT_IRQ
    |-> pin_out_out[0] == $past(port_latch_in[0]))
    else $error("pin not following port latch");
endmodule
bind ccu_top ccu_top_checker #(.SMALL_MEM(SMALL_MEM)) u_checker (
  .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .port_latch_in(port_latch_in), .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out),
  .irq_flag_out(irq_flag_out), .tmr16_reset_out(tmr16_reset_out)
);
`default_nettype wire

//--- sim/capture_compare_pwm_unit_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Bench drives channel 0 through capture, compare and pwm against a rule model
module capture_compare_pwm_unit_tb_top;
  import ccu_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] cap_pin = 7'h00;
  logic [6:0] port_latch = 7'h00;
  logic run = 1'b0;
  logic load = 1'b0;
  logic [15:0] load_val = 16'h0000;
  logic [7:0] rdata, t8_fine;
  logic [6:0] pin_out, pin_oe, irq_flag;
  logic [63:0] t16;
  logic [31:0] t8;
  logic [3:0] t8_per, t16_rst;
  int checks = 0;
  int mismatches = 0;
  int trig_cnt [4] = '{0, 0, 0, 0};
  logic [3:0] cap_mode [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int cap_edges [4] = '{1, 1, 4, 16};
  logic [3:0] cmp_mode [5] = '{4'h8, 4'hB, 4'h9, 4'hA, 4'h2};
  int pin_init [5] = '{0, 3, 1, 2, 0}; // 2 means port latch, 3 means not checked
  int pin_fin [5] = '{1, 3, 0, 2, 1};
  ccu_top #(.SMALL_MEM(1'b0)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .cap_pin_in(cap_pin),
    .port_latch_in(port_latch), .pin_out_out(pin_out), .pin_oe_out(pin_oe),
    .irq_flag_out(irq_flag), .tmr16_count_in(t16), .tmr8_count_in(t8),
    .tmr8_fine_in(t8_fine), .tmr8_period_in(t8_per), .tmr16_reset_out(t16_rst));
  ccu_timer_model timers (
    .clk_in(clk_in), .rst_in(rst_in), .run_in(run), .load_in(load), .load_val_in(load_val),
    .tmr16_reset_in(t16_rst), .tmr16_count_out(t16), .tmr8_count_out(t8),
    .tmr8_fine_out(t8_fine), .tmr8_period_out(t8_per));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // Count timer reset pulses per 16-bit timer
  always @(posedge clk_in) begin
    for (int k = 0; k < 4; k++) begin
      if (!rst_in && t16_rst[k]) trig_cnt[k]++;
    end
  end
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every bus task starts on the next edge, so strobes never collide
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic load_timers(input logic [15:0] val);
    @(posedge clk_in);
    load <= 1'b1;
    load_val <= val;
    @(posedge clk_in);
    load <= 1'b0;
  endtask
  task automatic pulse_pin();
    @(posedge clk_in);
    cap_pin <= {6'($urandom), 1'b1};
    repeat (3) @(posedge clk_in);
    cap_pin[0] <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // Readback from the access rules; flags are left out as matches may set them
  function automatic logic [7:0] reg_exp(input logic [4:0] a, input logic [7:0] d);
    if (a[4:2] != 3'h7) begin
      return (a[1:0] == 2'h3) ? 8'h00 : (a[1:0] == 2'h0) ? (d & 8'h3F) : d;
    end
    return (a == 5'h1C) ? (d & 8'hD7) : (a == 5'h1D) ? (d & 8'h17) : 8'h00;
  endfunction
  initial begin
    #800000;
    mismatches++;
    end_sim();
  end
  initial begin
    logic [7:0] d, d2;
    logic [15:0] v;
    int n, h, k;
    void'($urandom(54021));
    port_latch <= 7'($urandom);
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    // Reset values, then random write and readback of every address
    for (int a = 0; a < 32; a++) begin
      rd_reg(5'(a), d);
      check(16'(d), 16'h0000);
    end
    for (int a = 0; a < 32; a++) begin
      d = 8'($urandom);
      if (a[1:0] == 2'h0 && a[4:2] != 3'h7) d[3] = 1'b0;
      wr_reg(5'(a), d);
      rd_reg(5'(a), d2);
      if (a != 30) check(16'(d2), 16'(reg_exp(5'(a), d)));
    end
    // Slot 7 clears the low select group, so channel 0 captures from timer 1 again
    for (int a = 0; a < 8; a++) wr_reg(5'(4 * a), 8'h00);
    // Capture modes, twice each so the second capture overwrites the first
    for (int i = 0; i < 4; i++) begin
      wr_reg(5'h00, 8'h00);
      wr_reg(5'h00, {4'h3, cap_mode[i]});
      for (int r = 0; r < 2; r++) begin
        wr_reg(5'h1E, 8'h7F);
        v = 16'($urandom);
        load_timers(v);
        repeat (cap_edges[i] - 1) pulse_pin();
        #1 check(16'(irq_flag[0]), 16'h0000);
        pulse_pin();
        repeat (3) @(posedge clk_in);
        #1 check(16'(irq_flag[0]), 16'h0001);
        rd_reg(5'h01, d);
        rd_reg(5'h02, d2);
        check({d2, d}, v);
      end
    end
    // Compare modes; odd entries select the second timer pair for channel 0
    for (int i = 0; i < 5; i++) begin
      k = i % 2;
      wr_reg(5'h1C, 8'(k));
      wr_reg(5'h00, 8'h00);
      v = 16'($urandom) & 16'h7FFF | 16'h0100;
      load_timers(v);
      n = int'(v) + 20 + k * 4096;
      wr_reg(5'h01, n[7:0]);
      wr_reg(5'h02, n[15:8]);
      wr_reg(5'h00, {4'h3, cmp_mode[i]});
      wr_reg(5'h1E, 8'h7F);
      trig_cnt = '{0, 0, 0, 0};
      repeat (2) @(posedge clk_in);
      if (pin_init[i] != 3) check(16'(pin_out[0]),
          (pin_init[i] == 2) ? 16'(port_latch[0]) : 16'(pin_init[i]));
      run <= 1'b1;
      repeat (40) @(posedge clk_in);
      run <= 1'b0;
      #1 check(16'(irq_flag[0]), 16'h0001);
      if (pin_fin[i] != 3) check(16'(pin_out[0]),
          (pin_fin[i] == 2) ? 16'(port_latch[0]) : 16'(pin_fin[i]));
      check(16'(trig_cnt[k]), (cmp_mode[i] == 4'hB) ? 16'h0001 : 16'h0000);
      check(16'(trig_cnt[0] + trig_cnt[1] + trig_cnt[2] + trig_cnt[3]), 16'(trig_cnt[k]));
    end
    // PWM: high time over one full period equals the 10-bit duty
    wr_reg(5'h1C, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr_reg(5'h00, 8'h00);
      d = 8'($urandom_range(240, 8));
      n = $urandom_range(3, 0);
      wr_reg(5'h01, d);
      wr_reg(5'h00, {2'b00, 2'(n), (i == 0) ? 4'hC : 4'hF});
      // Look past the write edge so a period pulse seen before PWM was on is skipped
      #1;
      for (int w = 0; w < 1100 && !t8_per[0]; w++) begin
        @(posedge clk_in);
        #1;
      end
      h = 0;
      repeat (1024) begin
        @(posedge clk_in);
        #1 h += int'(pin_out[0]);
      end
      check(16'(h), {6'h00, d, 2'(n)});
      rd_reg(5'h02, d2);
      check(16'(d2), 16'(d));
    end
    wr_reg(5'h00, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
